// file: exception_pend_state_reg.sv
`timescale 1ns/1ps

module exception_pend_state_reg #(
  parameter int NIRQ = 32,
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_request,
  input wire logic tick_event,
  input wire logic [NIRQ-1:0] irq_pending,
  input wire logic [NIRQ-1:0] irq_enable,
  input wire logic [NIRQ-1:0][exc_state_pkg::PRIO_W-1:0] irq_priority,
  input wire logic [exc_state_pkg::PRIO_W-1:0] dcall_priority,
  input wire logic [exc_state_pkg::PRIO_W-1:0] tick_priority,
  input wire logic core_priority_mask_reg,
  input wire logic core_halted,
  input wire logic debug_interrupt_mask,
  input wire exc_state_pkg::exc_event_t handler_entry,
  input wire exc_state_pkg::exc_event_t handler_return,
  output logic take_exception,
  output logic [exc_state_pkg::EXC_NUM_W-1:0] take_number,
  output logic nmi_pending,
  output logic dcall_pending,
  output logic tick_pending
);
  import exc_state_pkg::*;

  localparam int NSRC = NIRQ + 3;

  // ****************************************
  // apb decode
  // ****************************************
  logic hit;
  logic wr_en;
  logic rd_setup;

  assign hit = (paddr == ICS_OFFSET[ADDR_W-1:0]);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // pending state
  // ****************************************
  logic nmi_q, nmi_d;
  logic dcall_q, dcall_d;
  logic tick_q, tick_d;
  logic nmi_req_q, nmi_req_d;
  logic nmi_rise;
  logic enter_nmi, enter_dcall, enter_tick;

  assign nmi_rise = nmi_request && !nmi_req_q;
  assign enter_nmi = handler_entry.valid && handler_entry.num == EXC_NMI;
  assign enter_dcall = handler_entry.valid && handler_entry.num == EXC_DCALL;
  assign enter_tick = handler_entry.valid && handler_entry.num == EXC_TICK;

  // sets win over clears arriving in the same cycle
  always_comb begin
    nmi_req_d = nmi_request;
    nmi_d = nmi_q;
    dcall_d = dcall_q;
    tick_d = tick_q;
    if (enter_nmi) begin
      nmi_d = 1'b0;
    end
    if (nmi_rise || (wr_en && pwdata[NMI_SET_POS])) begin
      nmi_d = 1'b1;
    end
    if (enter_dcall || (wr_en && pwdata[DCALL_CLR_POS])) begin
      dcall_d = 1'b0;
    end
    if (wr_en && pwdata[DCALL_SET_POS]) begin
      dcall_d = 1'b1;
    end
    if (enter_tick || (wr_en && pwdata[TICK_CLR_POS])) begin
      tick_d = 1'b0;
    end
    if (tick_event || (wr_en && pwdata[TICK_SET_POS])) begin
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_req_q <= 1'b0;
      nmi_q <= PEND_RST;
      dcall_q <= PEND_RST;
      tick_q <= PEND_RST;
    end else begin
      nmi_req_q <= nmi_req_d;
      nmi_q <= nmi_d;
      dcall_q <= dcall_d;
      tick_q <= tick_d;
    end
  end

  assign nmi_pending = nmi_q;
  assign dcall_pending = dcall_q;
  assign tick_pending = tick_q;

  // ****************************************
  // active exception number
  // ****************************************
  logic [EXC_NUM_W-1:0] act_q, act_d;

  always_comb begin
    act_d = act_q;
    if (handler_entry.valid) begin
      act_d = handler_entry.num;
    end else if (handler_return.valid) begin
      act_d = handler_return.num;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= ACT_NUM_RST;
    end else begin
      act_q <= act_d;
    end
  end

  // ****************************************
  // priority selection
  // ****************************************
  logic [NSRC-1:0] src_req;
  logic [NSRC-1:0][EPRIO_W-1:0] src_prio;
  logic [NSRC-1:0][EXC_NUM_W-1:0] src_num;
  logic pend_found;
  logic [EPRIO_W-1:0] pend_prio;
  logic [EXC_NUM_W-1:0] pend_num;
  logic [EPRIO_W-1:0] act_prio;
  logic ext_pend;
  logic preempt;

  // masked by enables only; core priority mask is not applied here
  always_comb begin
    src_req[0] = nmi_q;
    src_prio[0] = EPRIO_NMI;
    src_num[0] = EXC_NMI;
    src_req[1] = dcall_q;
    src_prio[1] = {1'b0, dcall_priority} + 3'h1;
    src_num[1] = EXC_DCALL;
    src_req[2] = tick_q;
    src_prio[2] = {1'b0, tick_priority} + 3'h1;
    src_num[2] = EXC_TICK;
    for (int i = 0; i < NIRQ; i++) begin
      src_req[i + 3] = irq_pending[i] && irq_enable[i];
      src_prio[i + 3] = {1'b0, irq_priority[i]} + 3'h1;
      src_num[i + 3] = EXC_IRQ0 + EXC_NUM_W'(i);
    end
  end

  exc_prio_select #(
    .N(NSRC)
  ) u_select (
    .req(src_req),
    .prio(src_prio),
    .num(src_num),
    .found(pend_found),
    .best_prio(pend_prio),
    .best_num(pend_num)
  );

  // priority of the running handler, EPRIO_FIXED (0) when none or nmi
  always_comb begin
    act_prio = EPRIO_FIXED;
    if (act_q == EXC_DCALL) begin
      act_prio = src_prio[1];
    end else if (act_q == EXC_TICK) begin
      act_prio = src_prio[2];
    end else if (act_q >= EXC_IRQ0 && act_q < EXC_IRQ0 + EXC_NUM_W'(NIRQ)) begin
      act_prio = src_prio[3 + int'(act_q - EXC_IRQ0)];
    end
  end

  assign ext_pend = |(irq_pending & irq_enable);
  assign preempt = pend_found && (act_q == EXC_NONE || pend_prio < act_prio);

  // ****************************************
  // core take request
  // ****************************************
  // nmi bypasses the priority mask; halted core takes nothing
  always_comb begin
    take_exception = 1'b0;
    take_number = pend_num;
    if (!core_halted && !debug_interrupt_mask && preempt) begin
      take_exception = (pend_num == EXC_NMI) || !core_priority_mask_reg;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_d, rd_q;

  always_comb begin
    rd_d = rd_q;
    if (rd_setup) begin
      rd_d = 32'h0000_0000;
      if (hit) begin
        rd_d[NMI_SET_POS] = nmi_q;
        rd_d[DCALL_SET_POS] = dcall_q;
        rd_d[TICK_SET_POS] = tick_q;
        rd_d[PREEMPT_POS] = core_halted && preempt;
        rd_d[EXT_PEND_POS] = ext_pend;
        rd_d[PEND_NUM_LSB +: EXC_NUM_W] = pend_found ? pend_num : EXC_NONE;
        rd_d[ACT_NUM_LSB +: EXC_NUM_W] = act_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign prdata = rd_q;

endmodule // exception_pend_state_reg

// file: exc_state_pkg.sv
package exc_state_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] ICS_OFFSET = 16'hed04;

  // ****************************************
  // field positions
  // ****************************************
  localparam int NMI_SET_POS = 31;
  localparam int DCALL_SET_POS = 28;
  localparam int DCALL_CLR_POS = 27;
  localparam int TICK_SET_POS = 26;
  localparam int TICK_CLR_POS = 25;
  localparam int PREEMPT_POS = 23;
  localparam int EXT_PEND_POS = 22;
  localparam int PEND_NUM_LSB = 12;
  localparam int ACT_NUM_LSB = 0;

  // ****************************************
  // exception numbers and widths
  // ****************************************
  localparam int EXC_NUM_W = 9;
  localparam int PRIO_W = 2;
  localparam int EPRIO_W = 3;
  localparam logic [EXC_NUM_W-1:0] EXC_NONE = 9'h000;
  localparam logic [EXC_NUM_W-1:0] EXC_NMI = 9'h002;
  localparam logic [EXC_NUM_W-1:0] EXC_DCALL = 9'h00e;
  localparam logic [EXC_NUM_W-1:0] EXC_TICK = 9'h00f;
  localparam logic [EXC_NUM_W-1:0] EXC_IRQ0 = 9'h010;
  localparam logic [EPRIO_W-1:0] EPRIO_NMI = 3'h0;
  localparam logic [EPRIO_W-1:0] EPRIO_FIXED = 3'h0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [EXC_NUM_W-1:0] ACT_NUM_RST = 9'h000;
  localparam logic PEND_RST = 1'b0;

  // core handler entry or return event
  typedef struct packed {
    logic valid;
    logic [EXC_NUM_W-1:0] num;
  } exc_event_t;

endpackage

// file: exc_prio_select.sv
`timescale 1ns/1ps

// ****************************************
// picks the best-priority pending source
// ****************************************
module exc_prio_select #(
  parameter int N = 35
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][exc_state_pkg::EPRIO_W-1:0] prio,
  input wire logic [N-1:0][exc_state_pkg::EXC_NUM_W-1:0] num,
  output logic found,
  output logic [exc_state_pkg::EPRIO_W-1:0] best_prio,
  output logic [exc_state_pkg::EXC_NUM_W-1:0] best_num
);
  import exc_state_pkg::*;

  // lower priority value wins, ties go to the lower index
  always_comb begin
    found = 1'b0;
    best_prio = '1;
    best_num = EXC_NONE;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || prio[i] < best_prio)) begin
        found = 1'b1;
        best_prio = prio[i];
        best_num = num[i];
      end
    end
  end

endmodule // exc_prio_select

// file: exception_pend_state_checker.sv
`timescale 1ns/1ps

// ****************************************
// port checks
// ****************************************
module exception_pend_state_checker
  import exc_state_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nmi_request,
  input wire logic tick_event,
  input wire logic core_halted,
  input wire exc_state_pkg::exc_event_t handler_entry,
  input wire logic [exc_state_pkg::EXC_NUM_W-1:0] take_number,
  input wire logic nmi_pending,
  input wire logic dcall_pending,
  input wire logic tick_pending
);
  wire hit = paddr == ICS_OFFSET;
  wire wr = psel && penable && pwrite && hit;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_setup;
    psel && !penable && !pwrite && hit;
  endsequence
  chk_nmi_set: assert property (
    (wr && pwdata[31]) || $rose(nmi_request) |=> nmi_pending) else $error("nmi set");
  chk_dcall_set: assert property (
    wr && pwdata[28] |=> dcall_pending) else $error("dcall set");
  chk_dcall_clr: assert property (
    wr && pwdata[27] && !pwdata[28] |=> !dcall_pending) else $error("dcall clear");
  chk_tick_set: assert property (
    (wr && pwdata[26]) || tick_event |=> tick_pending) else $error("tick set");
  chk_tick_clr: assert property (
    wr && pwdata[25] && !pwdata[26] && !tick_event |=> !tick_pending)
    else $error("tick clear");
  chk_dcall_only: assert property (
    !dcall_pending && !(wr && pwdata[28]) |=> !dcall_pending) else $error("dcall path");
  chk_nmi_entry: assert property (
    handler_entry.valid && handler_entry.num == EXC_NMI && !(wr && pwdata[31])
    && !$rose(nmi_request) |=> !nmi_pending) else $error("nmi entry");
  chk_nmi_best: assert property (
    nmi_pending |-> take_number == EXC_NMI) else $error("nmi number");
  chk_read_word: assert property (
    rd_setup |=> prdata[31] == $past(nmi_pending) && prdata[28] == $past(dcall_pending)
    && prdata[26] == $past(tick_pending) && prdata[30:29] == 2'h0 && !prdata[24]
    && !prdata[21] && prdata[11:9] == 3'h0 && (!prdata[23] || $past(core_halted)))
    else $error("read word");
  chk_bus_answer: assert property (
    psel && penable |-> pready && pslverr == !hit) else $error("bus answer");
endmodule // exception_pend_state_checker

bind exception_pend_state_reg exception_pend_state_checker #(.ADDR_W(ADDR_W)) chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .nmi_request, .tick_event, .core_halted, .handler_entry, .take_number,
  .nmi_pending,
  .dcall_pending, .tick_pending
);

// file: exception_pend_state_reg_tb.sv
`timescale 1ns/1ps

module exception_pend_state_reg_tb;
  import exc_state_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, take_exception, nmi_pending, dcall_pending, tick_pending;
  logic nmi_request = 0, tick_event = 0;
  logic core_priority_mask_reg = 0, core_halted = 0, debug_interrupt_mask = 0;
  logic [31:0] irq_pending = '0, irq_enable = '0;
  logic [31:0][1:0] irq_priority = {32{2'h2}};
  logic [1:0] dcall_priority = 2'h3, tick_priority = 2'h0;
  exc_event_t handler_entry = '0, handler_return = '0;
  logic [8:0] take_number;
  int errors = 0, checked = 0;
  exception_pend_state_reg exception_pend_state_reg_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .nmi_request, .tick_event, .irq_pending, .irq_enable, .irq_priority,
    .dcall_priority, .tick_priority, .core_priority_mask_reg, .core_halted,
    .debug_interrupt_mask, .handler_entry, .handler_return, .take_exception,
    .take_number, .nmi_pending, .dcall_pending, .tick_pending
  );
  always #5 pclk = ~pclk;
  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for the answer; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    xfer(1'b1, ICS_OFFSET, d);
  endtask
  task automatic rx(input logic [31:0] e);
    xfer(1'b0, ICS_OFFSET, 32'h0);
    check(rd, e);
  endtask
  // pulse handler entry or return
  task automatic ev(input logic r, input logic [8:0] n);
    @(posedge pclk);
    if (r) handler_return <= {1'b1, n};
    else handler_entry <= {1'b1, n};
    @(posedge pclk);
    handler_entry <= '0;
    handler_return <= '0;
  endtask
  task end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rx(32'h0);
    wr(32'h6120_0e00);
    xfer(1'b1, 16'hed08, 32'h9000_0000);
    check(er, 1'b1);
    rx(32'h0);
    $display("test reset done at %0t", $time);
    wr(32'h1000_0000);
    rx(32'h1000_e000);
    wr(32'h0400_0000);
    wr(32'h0);
    rx(32'h1400_f000);
    wr(32'h0200_0000);
    rx(32'h1000_e000);
    wr(32'h0800_0000);
    rx(32'h0);
    check(dcall_pending, 1'b0);
    @(posedge pclk);
    tick_event <= 1'b1;
    @(posedge pclk);
    tick_event <= 1'b0;
    rx(32'h0400_f000);
    check(tick_pending, 1'b1);
    wr(32'h0200_0000);
    $display("test pend done at %0t", $time);
    irq_pending <= 32'h8;
    rx(32'h0);
    irq_enable <= 32'h8;
    core_priority_mask_reg <= 1'b1;
    rx(32'h0041_3000);
    check(take_exception, 1'b0);
    core_halted <= 1'b1;
    rx(32'h00c1_3000);
    core_halted <= 1'b0;
    core_priority_mask_reg <= 1'b0;
    @(posedge pclk);
    check(take_exception, 1'b1);
    check(take_number, 9'h013);
    debug_interrupt_mask <= 1'b1;
    @(posedge pclk);
    check(take_exception, 1'b0);
    debug_interrupt_mask <= 1'b0;
    irq_pending <= '0;
    ev(1'b0, 9'h013);
    rx(32'h0000_0013);
    ev(1'b1, 9'h000);
    rx(32'h0);
    $display("test irq done at %0t", $time);
    wr(32'h8000_0000);
    @(posedge pclk);
    check(nmi_pending, 1'b1);
    check(take_exception, 1'b1);
    rx(32'h8000_2000);
    ev(1'b0, EXC_NMI);
    rx(32'h0000_0002);
    nmi_request <= 1'b1;
    rx(32'h8000_2002);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    nmi_request <= 1'b0;
    rx(32'h0);
    $display("test nmi done at %0t", $time);
    end_of_test;
  end
endmodule // exception_pend_state_reg_tb
